// ---- verilog/ioe_expander.sv ----
/*
  Eight-bit port expander on a two-wire serial bus: protocol core,
  register set, change detector and pin drivers.
  Assumes raw pad inputs, pads that resolve open-drain lines from the
  enables, and nrst driven by the power-on reset of the supply.
*/
`timescale 1ns/1ps
`include "ioe_params.svh"

module ioe_expander (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_n_o,
  output logic int_n_oe,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  input wire ioe_pkg::ioe_byte_t port_pins_i,
  output ioe_pkg::ioe_byte_t port_pins_o,
  output ioe_pkg::ioe_byte_t port_pins_oe
);
  import ioe_pkg::*;

  localparam int FILT = `IOE_FILT_CYC;
  localparam int IRQ_VALID = `IOE_IRQ_VALID_CYC;
  localparam logic [4:0] SETTLE = 5'(`IOE_FILT_CYC + 4);

  ioe_link_if lk ();

  ioe_byte_t pins_f;
  logic [1:0] bus_f;
  logic [2:0] addr_f;
  logic [1:0] tgl_s;

  // pins, straps and the core's copy of the bus lines are filtered against spikes; the shifter takes scl and sda raw
  ioe_sync #(.W(8), .STABLE(FILT), .CW(5)) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(port_pins_i),
    .clean(pins_f)
  );
  ioe_sync #(.W(2), .STABLE(FILT), .CW(5)) u_bus_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({scl, sda_i}),
    .clean(bus_f)
  );
  ioe_sync #(.W(3), .STABLE(FILT), .CW(5)) u_addr_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({addr_sel_bit2, addr_sel_bit1, addr_sel_bit0}),
    .clean(addr_f)
  );
  // event toggles from the bus clock need no filtering
  ioe_sync #(.W(2), .STABLE(1), .CW(5)) u_tgl_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({lk.byte_tgl, lk.ack_tgl}),
    .clean(tgl_s)
  );

  ioe_i2c_link u_link (
    .scl(scl),
    .nrst(nrst),
    .sda_i(sda_i),
    .lk(lk.link)
  );

  logic scl_prev;
  logic sda_prev;
  logic byte_prev;
  logic ack_prev;
  logic in_frame;
  logic link_run;
  ioe_state_t state;
  ioe_state_t next_state;
  logic [`IOE_CMD_MSB:0] cmd;
  ioe_byte_t out_reg;
  ioe_byte_t pol;
  ioe_byte_t dir;
  ioe_byte_t seen;
  ioe_byte_t tx_byte;
  logic ack_drive;
  logic tx_en;
  logic [4:0] settle;
  logic drive_low;

  wire scl_f = bus_f[1];
  wire sda_f = bus_f[0];
  // start and stop are sda edges while scl stays high
  wire start_ev = scl_f & scl_prev & sda_prev & ~sda_f;
  wire stop_ev = scl_f & scl_prev & ~sda_prev & sda_f;
  wire byte_ev = (tgl_s[1] != byte_prev) & link_run;
  wire ack_ev = (tgl_s[0] != ack_prev) & link_run;
  wire [6:0] own_addr = {`IOE_ADDR_FIXED, addr_f};
  wire addr_hit = lk.rx_byte[7:1] == own_addr;
  wire rd_req = lk.rx_byte[`IOE_RW_BIT];
  wire armed = settle == SETTLE;
  wire wr_en = byte_ev & (state == st_wdata);
  wire cmd_in = cmd == `IOE_CMD_INPUT;
  wire cmd_out = cmd == `IOE_CMD_OUTPUT;
  wire cmd_pol = cmd == `IOE_CMD_POLARITY;
  wire cmd_dir = cmd == `IOE_CMD_DIR;
  // ack (sda low) before each byte the device sends; before the first it is the device's own address ack
  wire load = ack_ev & (state == st_rdata) & ~lk.ack_sda;
  // snapshot taken at the ack edge clears the pending change
  wire capture = (load & cmd_in) | ~armed;
  wire [7:0] rd_input = pins_f ^ pol;
  wire [7:0] rd_value = cmd_in ? rd_input :
                        cmd_out ? out_reg :
                        cmd_pol ? pol : dir;
  // only pins set as inputs may differ from the snapshot
  wire [7:0] mism = (pins_f ^ seen) & dir;
  // a fresh snapshot leaves later changes free to mismatch again
  wire next_irq = armed & (|mism);
  // a pin returning to its old level drops the mismatch itself
  wire ack_set = byte_ev & (state == st_addr ? addr_hit :
                            state == st_cmd || state == st_wdata);
  wire tx_set = byte_ev & (state == st_addr) & addr_hit & rd_req;
  wire nack = ack_ev & (state == st_rdata) & lk.ack_sda;
  wire next_in_frame = start_ev | (in_frame & ~stop_ev);
  // the shifter is parked from every start or stop until scl goes low inside a frame
  wire next_link_run = (start_ev | stop_ev) ? 1'b0 :
                       (in_frame & ~scl_f) ? 1'b1 : link_run;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: next_state = st_idle;
      st_addr: begin
        if (byte_ev) begin
          // other slaves' traffic is watched but never acted on
          next_state = !addr_hit ? st_ignore :
                       rd_req ? st_rdata : st_cmd;
        end
      end
      st_cmd: begin
        if (byte_ev) begin
          next_state = st_wdata;
        end
      end
      st_wdata: next_state = st_wdata;
      st_rdata: begin
        if (nack) begin
          next_state = st_ignore;
        end
      end
      st_ignore: next_state = st_ignore;
      default: next_state = st_idle;
    endcase
    if (start_ev) begin
      next_state = st_addr;
    end else if (stop_ev) begin
      next_state = st_idle;
    end
  end

  // nrst is the supply's power-on reset; all state returns to default
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_prev <= 1'b0;
      sda_prev <= 1'b0;
      byte_prev <= 1'b0;
      ack_prev <= 1'b0;
      in_frame <= 1'b0;
      link_run <= 1'b0;
      state <= st_idle;
    end else begin
      scl_prev <= scl_f;
      sda_prev <= sda_f;
      byte_prev <= tgl_s[1];
      ack_prev <= tgl_s[0];
      in_frame <= next_in_frame;
      link_run <= next_link_run;
      state <= next_state;
    end
  end

  // command is kept until a new one arrives, so reads repeat it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= `IOE_CMD_INPUT;
    end else if (byte_ev && state == st_cmd) begin
      cmd <= lk.rx_byte[`IOE_CMD_MSB:0];
    end
  end

  // the input register is read only; writes to it fall away
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_reg <= `IOE_OUTPUT_RST;
      pol <= `IOE_POLARITY_RST;
      dir <= `IOE_DIR_RST;
    end else if (wr_en) begin
      if (cmd_out) begin
        out_reg <= lk.rx_byte;
      end
      if (cmd_pol) begin
        pol <= lk.rx_byte;
      end
      if (cmd_dir) begin
        dir <= lk.rx_byte;
      end
    end
  end

  // snapshot follows the pins until the filters settle after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle <= 5'h00;
      seen <= 8'h00;
    end else begin
      if (!armed) begin
        settle <= settle + 5'h01;
      end
      if (capture) begin
        seen <= pins_f;
      end
    end
  end

  // a change racing the ack edge lands in the snapshot and is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_n_oe <= 1'b0;
    end else begin
      // spurious flag after output-to-input switch is accepted
      int_n_oe <= next_irq;
    end
  end

  // open drain: the pad only ever pulls low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= 1'b0;
    end
  end
  assign int_n_o = drive_low;
  assign sda_o = drive_low;
  assign sda_oe = lk.sda_oe;

  // both drivers off on inputs, latch value on outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_pins_oe <= 8'h00;
      port_pins_o <= `IOE_OUTPUT_RST;
    end else begin
      port_pins_oe <= ~dir;
      port_pins_o <= out_reg;
    end
  end

  // words toward the shifter change well away from its clock edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_drive <= 1'b0;
      tx_en <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      ack_drive <= ~(start_ev | stop_ev | ack_ev) & (ack_set | ack_drive);
      tx_en <= ~(start_ev | stop_ev | nack) & (tx_set | tx_en);
      if (load) begin
        tx_byte <= rd_value;
      end
    end
  end
  assign lk.link_rst_n = link_run;
  assign lk.ack_drive = ack_drive;
  assign lk.tx_en = tx_en;
  assign lk.tx_byte = tx_byte;

  logic mism_raw;
  logic [10:0] unflagged;
  assign mism_raw = |((port_pins_i ^ seen) & dir);
  // cycles a raw pin mismatch has gone without the flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unflagged <= 11'h000;
    end else if (!mism_raw || int_n_oe || capture || wr_en) begin
      unflagged <= 11'h000;
    end else begin
      unflagged <= unflagged + 11'h001;
    end
  end

  AST_IRQ_VALID:
  assert property (@(posedge clk) disable iff (!nrst)
    unflagged < 11'(IRQ_VALID))
  else $error("pin change not flagged within valid delay");

  AST_IRQ_CLEAR:
  assert property (@(posedge clk) disable iff (!nrst)
    capture ##1 $stable(pins_f) |=> !int_n_oe)
  else $error("interrupt still pending after port read");

  AST_OUT_QUIET:
  assert property (@(posedge clk) disable iff (!nrst)
    ((pins_f & dir) == (seen & dir)) |=> !int_n_oe)
  else $error("output pin raised interrupt");

  AST_FOREIGN:
  assert property (@(posedge clk) disable iff (!nrst)
    (state == st_ignore) |=> $stable(seen) && $stable(cmd))
  else $error("foreign traffic changed detection state");

  AST_DIR_PIN:
  assert property (@(posedge clk) disable iff (!nrst)
    wr_en && cmd_dir |-> ##2 port_pins_oe == ~$past(lk.rx_byte, 2))
  else $error("direction write not reflected at pin enables");

  AST_OUT_PIN:
  assert property (@(posedge clk) disable iff (!nrst)
    wr_en && cmd_out |-> ##2 port_pins_o == $past(lk.rx_byte, 2))
  else $error("output write not reflected at pins");

  AST_RESET:
  assert property (@(posedge clk) disable iff (!nrst)
    !$past(nrst) |-> port_pins_oe == 8'h00 && !int_n_oe && !sda_oe)
  else $error("pins not inputs after reset");

  AST_ADDR_ACK:
  assert property (@(posedge clk) disable iff (!nrst)
    byte_ev && state == st_addr && !start_ev && !stop_ev
    |=> ack_drive == $past(addr_hit))
  else $error("address acknowledge wrong");

  AST_CMD_KEEP:
  assert property (@(posedge clk) disable iff (!nrst)
    !(byte_ev && state == st_cmd) |=> $stable(cmd))
  else $error("command changed without command byte");

  AST_INPUT_RD:
  assert property (@(posedge clk) disable iff (!nrst)
    load && cmd_in |=> tx_byte == $past(pins_f ^ pol))
  else $error("input read value not polarity adjusted");

  AST_RO_INPUT:
  assert property (@(posedge clk) disable iff (!nrst)
    wr_en && cmd_in |=> $stable(out_reg) && $stable(pol) && $stable(dir))
  else $error("write to input register changed state");
endmodule

// ---- verilog/ioe_params.svh ----
/*
  Command codes, bit positions, reset values and timing counts for the
  port expander. Included by every design file that needs them.
*/
`ifndef IOE_PARAMS_SVH
`define IOE_PARAMS_SVH
`define IOE_CMD_INPUT 2'h0
`define IOE_CMD_OUTPUT 2'h1
`define IOE_CMD_POLARITY 2'h2
`define IOE_CMD_DIR 2'h3
`define IOE_CMD_MSB 1
`define IOE_RW_BIT 0
`define IOE_ADDR_FIXED 4'h7
`define IOE_OUTPUT_RST 8'hff
`define IOE_POLARITY_RST 8'h00
`define IOE_DIR_RST 8'hff
`define IOE_CLK_NS 4
`define IOE_SPIKE_NS 50
`define IOE_FILT_CYC ((`IOE_SPIKE_NS + `IOE_CLK_NS - 1) / `IOE_CLK_NS)
`define IOE_IRQ_VALID_NS 4000
`define IOE_IRQ_VALID_CYC (`IOE_IRQ_VALID_NS / `IOE_CLK_NS)
`endif

// ---- verilog/ioe_pkg.sv ----
/*
  Types shared by the port expander modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ioe_pkg;
  typedef logic [7:0] ioe_byte_t;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_cmd = 3'b010,
    st_wdata = 3'b011,
    st_rdata = 3'b100,
    st_ignore = 3'b101
  } ioe_state_t;
endpackage

// ---- verilog/ioe_link_if.sv ----
/*
  Signals between the system-clock core and the bus-clock shifter.
  Assumes the core holds its outputs steady around bus clock edges.
*/
`timescale 1ns/1ps
interface ioe_link_if;
  import ioe_pkg::*;
  logic link_rst_n;
  ioe_byte_t rx_byte;
  logic byte_tgl;
  logic ack_tgl;
  logic ack_sda;
  logic ack_drive;
  logic tx_en;
  ioe_byte_t tx_byte;
  logic sda_oe;
  modport core (
    output link_rst_n, ack_drive, tx_en, tx_byte,
    input rx_byte, byte_tgl, ack_tgl, ack_sda, sda_oe
  );
  modport link (
    input link_rst_n, ack_drive, tx_en, tx_byte,
    output rx_byte, byte_tgl, ack_tgl, ack_sda, sda_oe
  );
endinterface

// ---- verilog/ioe_sync.sv ----
/*
  Two-flop synchroniser followed by a per-bit stability filter.
  Assumes inputs are asynchronous to clk; nrst is asynchronous.
*/
`timescale 1ns/1ps
module ioe_sync #(
  parameter int W = 1,
  parameter int STABLE = 1,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] clean
);
  logic [W-1:0] meta;
  logic [W-1:0] settled;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      settled <= '0;
    end else begin
      meta <= async_in;
      settled <= meta;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [CW-1:0] run;
      logic q;
      wire differs = settled[i] != q;
      wire done = run == CW'(STABLE - 1);
      // a level must hold STABLE cycles before it is passed on
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          run <= '0;
          q <= 1'b0;
        end else if (!differs) begin
          run <= '0;
        end else if (done) begin
          run <= '0;
          q <= settled[i];
        end else begin
          run <= run + CW'(1);
        end
      end
      assign clean[i] = q;
    end
  endgenerate
endmodule

// ---- verilog/ioe_i2c_link.sv ----
/*
  Bit shifter of the serial bus, clocked by the bus clock itself.
  Assumes the core resets it through link_rst_n between frames and
  releases it only while scl is low; core words are steady when read.
*/
`timescale 1ns/1ps
module ioe_i2c_link (
  input wire logic scl,
  input wire logic nrst,
  input wire logic sda_i,
  ioe_link_if.link lk
);
  import ioe_pkg::*;

  logic [3:0] bit_cnt;
  ioe_byte_t shreg;
  logic tx_mode;
  wire next_tx = lk.tx_en & ~lk.ack_sda;
  wire [2:0] tx_idx = 3'(4'h7 - bit_cnt);

  assign lk.rx_byte = shreg;

  // sda is sampled on the rising edge, as the bus protocol defines
  always_ff @(posedge scl or negedge lk.link_rst_n) begin
    if (!lk.link_rst_n) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      lk.ack_sda <= 1'b1;
    end else if (bit_cnt == 4'h8) begin
      bit_cnt <= 4'h0;
      lk.ack_sda <= sda_i;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg <= {shreg[6:0], sda_i};
    end
  end

  // toggles survive frame resets so the core never sees a false event
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      lk.byte_tgl <= 1'b0;
      lk.ack_tgl <= 1'b0;
    end else if (lk.link_rst_n) begin
      if (bit_cnt == 4'h7) begin
        lk.byte_tgl <= ~lk.byte_tgl;
      end
      if (bit_cnt == 4'h8) begin
        lk.ack_tgl <= ~lk.ack_tgl;
      end
    end
  end

  // sda changes only while scl is low
  always_ff @(negedge scl or negedge lk.link_rst_n) begin
    if (!lk.link_rst_n) begin
      lk.sda_oe <= 1'b0;
      tx_mode <= 1'b0;
    end else if (bit_cnt == 4'h8) begin
      lk.sda_oe <= lk.ack_drive & ~tx_mode;
    end else if (bit_cnt == 4'h0) begin
      tx_mode <= next_tx;
      lk.sda_oe <= next_tx & ~lk.tx_byte[7];
    end else begin
      lk.sda_oe <= tx_mode & ~lk.tx_byte[tx_idx];
    end
  end
endmodule

// ---- tb/ioe_i2c_master.sv ----
/*
  Bus master model: frames on scl/sda from its own 32 ns tick.
  Assumes the bench resolves sda from sda_low, the slave and a pull-up.
*/
`timescale 1ns/1ps
module ioe_i2c_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic lclk;
  // tick unrelated in phase to clk; scl itself stands still between frames
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // data moves 128 ns after scl falls, clear of the filter skew
  task automatic bit_io(input logic b, output logic r);
    tk(4);
    sda_low <= ~b;
    tk(37);
    scl <= 1'b1;
    tk(1);
    r = sda;
    tk(19);
    scl <= 1'b0;
  endtask
  task automatic start();
    tk(4);
    sda_low <= 1'b0;
    tk(20);
    scl <= 1'b1;
    tk(20);
    sda_low <= 1'b1;
    tk(20);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tk(4);
    sda_low <= 1'b1;
    tk(37);
    scl <= 1'b1;
    tk(20);
    sda_low <= 1'b0;
    tk(41);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // no ack on the address ends the frame at once
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
      input logic [7:0] d, output logic [2:0] ak);
    start();
    put({a, 1'b0}, ak[2]);
    ak[1:0] = 2'b00;
    if (ak[2]) put(c, ak[1]);
    if (ak[2]) put(d, ak[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
      output logic ak);
    start();
    put({a, 1'b1}, ak);
    d = 8'h00;
    if (ak) get(1'b1, d);
    stop();
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the port expander: master model on the bus,
  pin levels driven outside, interrupt line seen through its pull-up.
  Assumes a 250 MHz clk and the master's own tick for scl.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module tb;
  import ioe_pkg::*;
  logic clk, nrst, scl, m_low, sda, sda_o, sda_oe;
  logic int_n_o, int_n_oe, int_line, a1;
  logic [2:0] straps, ak;
  ioe_byte_t ext, pins, po, poe, rv;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // straps 101 give 0111101; the other slave sits at 0111000
  localparam logic [6:0] ME = 7'h3d;
  localparam logic [6:0] OTHER = 7'h38;
  assign sda = ~(m_low | (sda_oe & ~sda_o));
  assign int_line = ~(int_n_oe & ~int_n_o);
  assign pins = (poe & po) | (~poe & ext);
  ioe_expander ioe_expander_inst (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe),
    .addr_sel_bit0(straps[0]), .addr_sel_bit1(straps[1]),
    .addr_sel_bit2(straps[2]), .port_pins_i(pins),
    .port_pins_o(po), .port_pins_oe(poe)
  );
  ioe_i2c_master ioe_i2c_master_inst (
    .scl(scl), .sda_low(m_low), .sda(sda)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // frames take about 85k cycles in all
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 96000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setp(input ioe_byte_t v);
    @(posedge clk);
    ext <= v;
  endtask
  // bounded by the 1000-cycle interrupt valid time
  task automatic wait_int(input logic e);
    for (int i = 0; i < 1000 && int_line !== e; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    nrst = 1'b0;
    ext = 8'h00;
    straps = 3'b101;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(40);
    `CHK("pins_oe", 8'h00, poe)
    `CHK("pins_o", 8'hff, po)
    `CHK("int", 1'b1, int_line)
    `CHK("sda_oe", 1'b0, sda_oe)
    $display("test reset done");
    ioe_i2c_master_inst.wr(ME, 8'h03, 8'h0f, ak);
    tick(40);
    `CHK("acks", 3'b111, ak)
    `CHK("pins_oe", 8'hf0, poe)
    `CHK("pins", 8'hf0, pins)
    tick(1000);
    `CHK("int", 1'b1, int_line)
    $display("test direction done");
    ioe_i2c_master_inst.wr(ME, 8'h01, 8'h5a, ak);
    tick(40);
    `CHK("acks", 3'b111, ak)
    `CHK("pins", 8'h50, pins)
    ioe_i2c_master_inst.rd(ME, rv, a1);
    `CHK("ack", 1'b1, a1)
    `CHK("output", 8'h5a, rv)
    $display("test output done");
    ioe_i2c_master_inst.wr(ME, 8'h02, 8'h03, ak);
    `CHK("acks", 3'b111, ak)
    ioe_i2c_master_inst.wr(ME, 8'h00, 8'hff, ak);
    `CHK("acks", 3'b111, ak)
    $display("test polarity done");
    setp(8'h01);
    wait_int(1'b0);
    `CHK("int", 1'b0, int_line)
    setp(8'h00);
    wait_int(1'b1);
    `CHK("int", 1'b1, int_line)
    setp(8'h02);
    wait_int(1'b0);
    `CHK("int", 1'b0, int_line)
    ioe_i2c_master_inst.wr(OTHER, 8'h01, 8'h00, ak);
    tick(40);
    `CHK("acks", 3'b000, ak)
    `CHK("pins", 8'h52, pins)
    `CHK("int", 1'b0, int_line)
    ioe_i2c_master_inst.rd(ME, rv, a1);
    wait_int(1'b1);
    `CHK("input", 8'h51, rv)
    `CHK("int", 1'b1, int_line)
    setp(8'h00);
    wait_int(1'b0);
    `CHK("int", 1'b0, int_line)
    setp(8'h02);
    wait_int(1'b1);
    `CHK("int", 1'b1, int_line)
    $display("test interrupt done");
    final_report();
  end
endmodule
